// File: hdl/chcfg_pkg.sv
`default_nettype none
package chcfg_pkg;
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h6b;
    localparam logic [7:0] ADDR_THERM_VOS = 8'h01;
    localparam logic [7:0] ADDR_ADC_DET = 8'h02;
    localparam logic [7:0] ADDR_CHG_BOOST = 8'h03;
    localparam logic [7:0] ADDR_CHG_CURR = 8'h04;
    // field positions
    localparam int BOOST_HOT_THRESHOLD_SEL_LSB = 6;
    localparam int BOOST_COLD_THRESHOLD_SEL_POS = 5;
    localparam int VOS_LSB = 0;
    localparam int CONV_POS = 7;
    localparam int RATE_POS = 6;
    localparam int BFREQ_POS = 5;
    localparam int ICO_POS = 4;
    localparam int RSV_LSB = 2;
    localparam int FDET_POS = 1;
    localparam int ADET_POS = 0;
    localparam int LOADEN_POS = 7;
    localparam int WDRST_POS = 6;
    localparam int OTG_POS = 5;
    localparam int CHG_POS = 4;
    localparam int SYSMIN_LSB = 1;
    localparam int MINVB_POS = 0;
    // values after reset
    localparam logic [1:0] BOOST_HOT_THRESHOLD_SEL_RST = 2'h0;
    localparam logic [0:0] BOOST_COLD_THRESHOLD_SEL_RST = 1'h0;
    localparam logic [4:0] VOS_RST = 5'h06;
    localparam logic [0:0] RATE_RST = 1'h0;
    localparam logic [0:0] BFREQ_RST = 1'h0;
    localparam logic [0:0] ICO_RST = 1'h1;
    localparam logic [1:0] RSV_RST = 2'h0;
    localparam logic [0:0] ADET_RST = 1'h1;
    localparam logic [0:0] LOADEN_RST = 1'h0;
    localparam logic [0:0] OTG_RST = 1'h0;
    localparam logic [0:0] CHG_RST = 1'h1;
    localparam logic [2:0] SYSMIN_RST = 3'h5;
    localparam logic [0:0] MINVB_RST = 1'h0;
    localparam logic [7:0] CURR_RST = 8'h20;
    // threshold arithmetic, millivolts
    localparam logic [16:0] VOS_STEP_MV = 17'h00064;
    localparam logic [16:0] VTH_MIN_MV = 17'h00f3c;
    localparam logic [16:0] VTH_MAX_MV = 17'h03bc4;
    localparam logic [15:0] INPUT_SUPPLY_VOLTAGE_DOUBLE_MV = 16'h1770;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_PTR = 7'h04,
        ST_WDATA = 7'h08,
        ST_RDATA = 7'h10,
        ST_ACK = 7'h20,
        ST_RACK = 7'h40
    } chcfg_state_t;
endpackage
`default_nettype wire

// File: hdl/chcfg_field.sv
`default_nettype none
module chcfg_field #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0,
    parameter bit WD_CLR = 1'b1
) (
    input wire logic clk,             // system clock
    input wire logic reset,           // sync reset, active high
    input wire logic reg_reset,       // register-reset command pulse
    input wire logic wd_expire,       // watchdog expiry pulse
    input wire logic wr_en,           // end-of-byte write strobe
    input wire logic [W-1:0] wr_data, // new field value
    output logic [W-1:0] q            // stored field
);
    logic [W-1:0] q_d;

    // a host write in the expiry cycle still lands; the host owns it
    always_comb begin
        q_d = q;
        if (reset || reg_reset) begin
            q_d = RST;
        end else if (wr_en) begin
            q_d = wr_data;
        end else if (WD_CLR && wd_expire) begin
            q_d = RST;
        end
    end

    always_ff @(posedge clk) begin
        q <= q_d;
    end
endmodule
`default_nettype wire

// File: hdl/chcfg_regs.sv
`default_nettype none
module chcfg_regs
    import chcfg_pkg::*;
(
    input wire logic clk,                // system clock, 100 MHz
    input wire logic reset,              // sync reset, active high
    input wire logic scl_in,             // serial clock from host
    input wire logic sda_in,             // serial data level on the wire
    output logic sda_out,                // serial data drive level
    output logic sda_oe,                 // high while pulling data low
    input wire logic reg_reset,          // register-reset command pulse
    input wire logic wd_expire,          // watchdog expiry pulse
    input wire logic adc_busy,           // converter running
    input wire logic adc_done,           // conversion finished pulse
    input wire logic detect_busy,        // source detection running
    input wire logic detect_done,        // forced detection done pulse
    input wire logic [15:0] input_supply_voltage_noload_mv, // unloaded supply, mV
    output logic host_mode,              // 1 host mode, 0 default mode
    output logic adc_start_pulse,        // one-cycle conversion request
    output logic force_detect_pulse,     // one-cycle detection request
    output logic watchdog_restart,       // one-cycle watchdog restart
    output logic [1:0] boost_hot_threshold_sel, // hot threshold code
    output logic boost_cold_threshold_sel, // cold threshold code
    output logic [4:0] input_voltage_limit_offset, // offset code
    output logic [15:0] input_voltage_limit_threshold, // mV
    output logic adc_rate_select,        // 1 continuous conversion
    output logic boost_frequency_select, // 1 low boost frequency
    output logic input_optimizer_enable, // optimizer on
    output logic auto_source_detection_enable, // detect on plug-in
    output logic battery_load_enable,    // battery load on
    output logic boost_output_enable,    // boost on
    output logic charging_enable,        // charging on
    output logic [2:0] system_minimum_voltage, // system floor code
    output logic boost_exit_low_sel,     // 1 exits boost at lower level
    output logic [7:0] charge_current_ctrl // fourth register image
);
    chcfg_state_t st_q, st_d, nxt_q, nxt_d;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic oe_q, oe_d;
    logic nack_q, nack_d;
    logic wr_en;
    logic ptr_ok, sh_ok;
    logic wr1, wr2, wr3, wr4;
    logic [7:0] rd_byte;
    logic [1:0] rsv;
    logic conv_q, conv_d, fdet_q, fdet_d, wdb_q, wdb_d;
    logic host_q, host_d;
    logic adc_go_q, adc_go_d, det_go_q, det_go_d;
    logic [16:0] os_mv, thr_sum;
    logic [15:0] thr_q, thr_d;

    // inputs are synchronous already; one stage gives edge history
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_ev = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_ev = scl_in & scl_q & ~sda_q & sda_in;
    assign ptr_ok = (ptr_q >= ADDR_THERM_VOS) && (ptr_q <= ADDR_CHG_CURR);
    assign sh_ok = (sh_q >= ADDR_THERM_VOS) && (sh_q <= ADDR_CHG_CURR);

    always_comb begin
        case (ptr_q)
            ADDR_THERM_VOS: rd_byte = {boost_hot_threshold_sel,
                boost_cold_threshold_sel, input_voltage_limit_offset};
            ADDR_ADC_DET: rd_byte = {conv_q | adc_busy | detect_busy,
                adc_rate_select, boost_frequency_select,
                input_optimizer_enable, rsv, fdet_q,
                auto_source_detection_enable};
            ADDR_CHG_BOOST: rd_byte = {battery_load_enable, wdb_q,
                boost_output_enable, charging_enable,
                system_minimum_voltage, boost_exit_low_sel};
            ADDR_CHG_CURR: rd_byte = charge_current_ctrl;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        st_d = st_q;
        nxt_d = nxt_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        nack_d = nack_q;
        wr_en = 1'b0;
        if (start_ev) begin
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_ev) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_in};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        st_d = ST_IDLE;
                        if (st_q == ST_ADDR) begin
                            if (sh_q[7:1] == I2C_TARGET_ADDR) begin
                                st_d = ST_ACK;
                                oe_d = 1'b1;
                                nxt_d = sh_q[0] ? ST_RDATA : ST_PTR;
                            end
                        end else if (st_q == ST_PTR) begin
                            if (sh_ok) begin
                                ptr_d = sh_q;
                                st_d = ST_ACK;
                                oe_d = 1'b1;
                                nxt_d = ST_WDATA;
                            end
                        end else if (ptr_ok) begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            st_d = ST_ACK;
                            oe_d = 1'b1;
                            nxt_d = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        st_d = nxt_q;
                        cnt_d = 4'h0;
                        oe_d = 1'b0;
                        if (nxt_q == ST_RDATA) begin
                            sh_d = rd_byte;
                            ptr_d = ptr_q + 8'h01;
                            oe_d = ~rd_byte[7];
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            oe_d = 1'b0;
                            st_d = ST_RACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_d = sda_in;
                    end else if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (nack_q) begin
                            st_d = ST_IDLE;
                            oe_d = 1'b0;
                        end else begin
                            st_d = ST_RDATA;
                            sh_d = rd_byte;
                            ptr_d = ptr_q + 8'h01;
                            oe_d = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            oe_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            scl_q <= scl_in;
            sda_q <= sda_in;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
            nack_q <= nack_d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign wr1 = wr_en && ptr_q == ADDR_THERM_VOS;
    assign wr2 = wr_en && ptr_q == ADDR_ADC_DET;
    assign wr3 = wr_en && ptr_q == ADDR_CHG_BOOST;
    assign wr4 = wr_en && ptr_q == ADDR_CHG_CURR;

    // codes go straight to the analog side, which decodes them
    chcfg_field #(.W(2), .RST(BOOST_HOT_THRESHOLD_SEL_RST)) u_boost_hot_threshold_sel (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr1),
        .wr_data(sh_q[BOOST_HOT_THRESHOLD_SEL_LSB +: 2]), .q(boost_hot_threshold_sel));
    chcfg_field #(.W(1), .RST(BOOST_COLD_THRESHOLD_SEL_RST)) u_boost_cold_threshold_sel (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr1),
        .wr_data(sh_q[BOOST_COLD_THRESHOLD_SEL_POS]), .q(boost_cold_threshold_sel));
    chcfg_field #(.W(5), .RST(VOS_RST), .WD_CLR(1'b0)) u_vos (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr1),
        .wr_data(sh_q[VOS_LSB +: 5]), .q(input_voltage_limit_offset));
    chcfg_field #(.W(1), .RST(RATE_RST)) u_rate (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr2),
        .wr_data(sh_q[RATE_POS]), .q(adc_rate_select));
    chcfg_field #(.W(1), .RST(BFREQ_RST)) u_bfreq (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr2 && !boost_output_enable),
        .wr_data(sh_q[BFREQ_POS]), .q(boost_frequency_select));
    chcfg_field #(.W(1), .RST(ICO_RST), .WD_CLR(1'b0)) u_ico (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr2),
        .wr_data(sh_q[ICO_POS]), .q(input_optimizer_enable));
    chcfg_field #(.W(2), .RST(RSV_RST), .WD_CLR(1'b0)) u_rsv (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr2),
        .wr_data(sh_q[RSV_LSB +: 2]), .q(rsv));
    chcfg_field #(.W(1), .RST(ADET_RST), .WD_CLR(1'b0)) u_adet (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr2),
        .wr_data(sh_q[ADET_POS]), .q(auto_source_detection_enable));
    chcfg_field #(.W(1), .RST(LOADEN_RST)) u_load (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr3),
        .wr_data(sh_q[LOADEN_POS]), .q(battery_load_enable));
    chcfg_field #(.W(1), .RST(OTG_RST)) u_otg (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr3),
        .wr_data(sh_q[OTG_POS]), .q(boost_output_enable));
    chcfg_field #(.W(1), .RST(CHG_RST)) u_chg (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr3),
        .wr_data(sh_q[CHG_POS]), .q(charging_enable));
    chcfg_field #(.W(3), .RST(SYSMIN_RST), .WD_CLR(1'b0)) u_smin (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr3),
        .wr_data(sh_q[SYSMIN_LSB +: 3]), .q(system_minimum_voltage));
    chcfg_field #(.W(1), .RST(MINVB_RST)) u_minvb (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr3),
        .wr_data(sh_q[MINVB_POS]), .q(boost_exit_low_sel));
    chcfg_field #(.W(8), .RST(CURR_RST)) u_curr (
        .clk(clk), .reset(reset), .reg_reset(reg_reset),
        .wd_expire(wd_expire), .wr_en(wr4),
        .wr_data(sh_q), .q(charge_current_ctrl));

    always_comb begin
        adc_go_d = wr2 && sh_q[CONV_POS] && !adc_rate_select;
        det_go_d = wr2 && sh_q[FDET_POS];
        wdb_d = wr3 && sh_q[WDRST_POS];
        conv_d = conv_q;
        fdet_d = fdet_q;
        host_d = host_q;
        if (reset || reg_reset) begin
            conv_d = 1'b0;
            fdet_d = 1'b0;
        end else begin
            // a request in the done or expiry cycle must not be lost,
            // else the pulse goes out while the bit reads idle
            if (adc_done || wd_expire) conv_d = 1'b0;
            if (adc_go_d) conv_d = 1'b1;
            if (detect_done || wd_expire) fdet_d = 1'b0;
            if (det_go_d) fdet_d = 1'b1;
        end
        if (reset) begin
            host_d = 1'b0;
        end else if (wr_en) begin
            host_d = 1'b1;
        end else if (wd_expire) begin
            host_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            adc_go_q <= 1'b0;
            det_go_q <= 1'b0;
            wdb_q <= 1'b0;
        end else begin
            adc_go_q <= adc_go_d;
            det_go_q <= det_go_d;
            wdb_q <= wdb_d;
        end
        conv_q <= conv_d;
        fdet_q <= fdet_d;
        host_q <= host_d;
    end

    assign host_mode = host_q;
    assign adc_start_pulse = adc_go_q;
    assign force_detect_pulse = det_go_q;
    assign watchdog_restart = wdb_q;

    // offset doubles on a high-voltage adapter, then clamp
    always_comb begin
        os_mv = VOS_STEP_MV * {12'h000, input_voltage_limit_offset};
        if (input_supply_voltage_noload_mv > INPUT_SUPPLY_VOLTAGE_DOUBLE_MV) begin
            os_mv = {os_mv[15:0], 1'b0};
        end
        thr_sum = {1'b0, input_supply_voltage_noload_mv} + os_mv;
        if (thr_sum < VTH_MIN_MV) begin
            thr_d = VTH_MIN_MV[15:0];
        end else if (thr_sum > VTH_MAX_MV) begin
            thr_d = VTH_MAX_MV[15:0];
        end else begin
            thr_d = thr_sum[15:0];
        end
    end

    always_ff @(posedge clk) begin
        thr_q <= reset ? VTH_MIN_MV[15:0] : thr_d;
    end

    assign input_voltage_limit_threshold = thr_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_freq_locked: assert property (
        wr2 && boost_output_enable |=> $stable(boost_frequency_select))
        else $error("boost frequency changed while boost enabled");
    a_wd_defaults: assert property (
        wd_expire && !wr_en && !reg_reset |=> charging_enable
        && !boost_output_enable && boost_hot_threshold_sel == BOOST_HOT_THRESHOLD_SEL_RST
        && !host_mode)
        else $error("watchdog expiry did not restore defaults");
    a_offset_kept: assert property (
        wd_expire && !wr_en && !reg_reset
        |=> $stable(input_voltage_limit_offset)
        && $stable(system_minimum_voltage))
        else $error("exempt field cleared by watchdog");
    a_host_entry: assert property (
        wr_en |=> host_mode)
        else $error("write did not enter host mode");
    a_busy_reads: assert property (
        adc_busy || detect_busy |-> rd_byte[CONV_POS] || ptr_q != ADDR_ADC_DET)
        else $error("start bit low during activity");
    a_thr_clamp: assert property (
        ##1 thr_q >= VTH_MIN_MV[15:0] && thr_q <= VTH_MAX_MV[15:0])
        else $error("threshold outside clamp");
    a_wd_return: assert property (
        watchdog_restart |=> !watchdog_restart)
        else $error("watchdog restart bit stuck");
    a_rate_ro: assert property (
        wr2 && adc_rate_select |=> !adc_start_pulse)
        else $error("start accepted under continuous rate");
    a_reg_defaults: assert property (
        reg_reset |=> input_voltage_limit_offset == VOS_RST
        && rsv == RSV_RST && auto_source_detection_enable)
        else $error("register reset missed a default");
    a_bad_ptr_nack: assert property (
        st_q == ST_PTR && scl_fall && cnt_q == BITS_PER_BYTE && !sh_ok
        && !start_ev && !stop_ev |=> st_q == ST_IDLE && !sda_oe)
        else $error("unmapped register was acknowledged");
    c_write: cover property (wr3 ##[1:1000] wr_en);
    c_read: cover property (st_q == ST_RACK ##1 st_q == ST_RDATA);
    c_conv: cover property (adc_start_pulse ##[1:1000] adc_done);
endmodule
`default_nettype wire

// File: dv/chcfg_host.sv
`default_nettype none
module chcfg_host (
    input wire logic clk, // system clock
    input wire logic sda, // resolved data line
    output logic scl,     // serial clock, host driven
    output logic sda_oe   // high while pulling data low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // nine bits, msb first; data moves only while clock is low
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            scl = 1'b0;
            w(2);
            sda_oe = ~d[i];
            w(2);
            scl = 1'b1;
            w(2);
            q[i] = sda;
            w(2);
        end
    endtask
    // p low gives start, p high gives stop
    task automatic cond(input logic p);
        scl = 1'b0;
        w(2);
        sda_oe = p;
        w(2);
        scl = 1'b1;
        w(4);
        sda_oe = ~p;
        w(4);
    endtask
endmodule
`default_nettype wire

// File: dv/tb_chcfg_regs.sv
`default_nettype none
module tb_chcfg_regs
    import chcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, rr = 1'b0, wdx = 1'b0;
    logic ab = 1'b0, ad = 1'b0, db = 1'b0, dd = 1'b0;
    logic [15:0] vb = 16'h0000;
    logic scl, h_oe, d_oe, hm, asp, wdr, fdp;
    logic [15:0] thr;
    logic [8:0] q;
    logic [7:0] rv;
    logic [2:0] ak;
    logic [7:0] dv [4] = '{8'h06, 8'h11, 8'h1a, 8'h20};
    logic [15:0] tv [4] = '{16'h1388, 16'h1770, 16'h1771, 16'h36b0};
    logic [15:0] te [4] = '{16'h1fa4, 16'h238c, 16'h2fa9, 16'h3bc4};
    int num_errors = 0, total_checks = 0, cyc = 0, n_asp = 0, n_wdr = 0;
    int c, n_fdp = 0;
    // open drain with pull-up: released reads high
    wire logic sda = ~(h_oe | d_oe);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_asp <= n_asp + int'(asp);
        n_wdr <= n_wdr + int'(wdr);
        n_fdp <= n_fdp + int'(fdp);
    end
    always @(negedge clk) begin
        if (cyc == 40000) begin
            num_errors++;
            report_and_stop();
        end
    end
    chcfg_regs DUT (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe(d_oe), .reg_reset(rr), .wd_expire(wdx),
        .adc_busy(ab), .adc_done(ad), .detect_busy(db), .detect_done(dd),
        .input_supply_voltage_noload_mv(vb), .host_mode(hm), .adc_start_pulse(asp),
        .force_detect_pulse(fdp), .watchdog_restart(wdr),
        .boost_hot_threshold_sel(), .boost_cold_threshold_sel(),
        .input_voltage_limit_offset(), .input_voltage_limit_threshold(thr),
        .adc_rate_select(), .boost_frequency_select(),
        .input_optimizer_enable(), .auto_source_detection_enable(),
        .battery_load_enable(), .boost_output_enable(), .charging_enable(),
        .system_minimum_voltage(), .boost_exit_low_sel(),
        .charge_current_ctrl());
    chcfg_host host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.cond(1'b0);
        host.xb({I2C_TARGET_ADDR, 2'b01}, q);
        ak[2] = ~q[0];
        host.xb({p, 1'b1}, q);
        ak[1] = ~q[0];
        host.xb({d, 1'b1}, q);
        ak[0] = ~q[0];
        host.cond(1'b1);
    endtask
    task automatic rc(input logic [7:0] p, input logic [7:0] e);
        host.cond(1'b0);
        host.xb({I2C_TARGET_ADDR, 2'b01}, q);
        host.xb({p, 1'b1}, q);
        host.cond(1'b0);
        host.xb({I2C_TARGET_ADDR, 2'b11}, q);
        host.xb(9'h1ff, q);
        rv = q[8:1];
        host.cond(1'b1);
        chk({8'h00, rv}, {8'h00, e});
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk(hm, 1'b0);
        chk(thr, 16'h0f3c);
        foreach (dv[i]) rc(8'(i + 1), dv[i]);
        $display("defaults test done");
        wr(8'h01, 8'hff);
        chk(ak, 3'b111);
        chk(hm, 1'b1);
        rc(8'h01, 8'hff);
        foreach (tv[i]) begin
            vb = tv[i];
            repeat (2) @(negedge clk);
            chk(thr, te[i]);
        end
        wdx = 1'b1;
        @(negedge clk);
        wdx = 1'b0;
        rc(8'h01, 8'h1f);
        chk(hm, 1'b0);
        $display("threshold test done");
        c = n_wdr;
        wr(8'h03, 8'hfb);
        chk(16'(n_wdr - c), 16'h0001);
        rc(8'h03, 8'hbb);
        wr(8'h02, 8'h31);
        rc(8'h02, 8'h11);
        c = n_asp;
        wr(8'h02, 8'h91);
        rc(8'h02, 8'h91);
        chk(16'(n_asp - c), 16'h0001);
        ad = 1'b1;
        @(negedge clk);
        ad = 1'b0;
        rc(8'h02, 8'h11);
        ab = 1'b1;
        rc(8'h02, 8'h91);
        ab = 1'b0;
        wr(8'h02, 8'h51);
        wr(8'h02, 8'hd1);
        rc(8'h02, 8'h51);
        db = 1'b1;
        rc(8'h02, 8'hd1);
        db = 1'b0;
        c = n_fdp;
        wr(8'h02, 8'h13);
        chk(16'(n_fdp - c), 16'h0001);
        rc(8'h02, 8'h13);
        dd = 1'b1;
        @(negedge clk);
        dd = 1'b0;
        rc(8'h02, 8'h11);
        wr(8'h04, 8'h5a);
        rc(8'h04, 8'h5a);
        $display("control test done");
        rr = 1'b1;
        @(negedge clk);
        rr = 1'b0;
        foreach (dv[i]) rc(8'(i + 1), dv[i]);
        wr(8'h02, 8'h31);
        rc(8'h02, 8'h31);
        wr(8'h05, 8'h00);
        chk(ak, 3'b100);
        host.cond(1'b0);
        host.xb({7'h6a, 2'b01}, q);
        chk(q[0], 1'b1);
        host.cond(1'b1);
        $display("reset and refusal test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
